// ---- hdl/sacs_pkg.sv ----
// shared constants and types of the serial converter cycle sequencer
package sacs_pkg;

	// ----------------------------------------------------------------
	// serial frame edge counts
	// ----------------------------------------------------------------
	localparam int          CNT_W             = 5;       // width of the edge counters
	localparam logic [4:0]  INIT_MIN_EDGES    = 5'h01;   // shortest initialization frame
	localparam logic [4:0]  INIT_MAX_EDGES    = 5'h08;   // longest initialization frame
	localparam logic [4:0]  SAMPLE_FIRST_EDGE = 5'h05;   // sampling opens on this clock
	localparam logic [4:0]  CONV_START_EDGE   = 5'h18;   // falling edge that launches conversion
	localparam logic [4:0]  LAST_BIT_EDGE     = 5'h0F;   // rising edge that shows the last bit
	localparam logic [4:0]  HIZ_RISE_EDGE     = 5'h11;   // rising edge that floats the output

	// ----------------------------------------------------------------
	// output words and reset values
	// ----------------------------------------------------------------
	localparam int          WORD_BITS         = 16;      // result width
	localparam logic [15:0] MARKER_WORD       = 16'hFF00; // init or aborted conversion marker
	localparam logic [15:0] WORD_RST          = 16'h0000; // output word after reset
	localparam logic [12:0] SYNC_RST          = 13'h1C00; // idle pin levels seen at reset

	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	localparam int          SYS_CLK_MHZ                = 200;  // system clock rate
	localparam int          OSC_PERIOD_NS              = 100;  // modelled oscillator period
	localparam int          CONV_OSC_CLOCKS            = 22;   // oscillator clocks per conversion
	localparam int          CONVERSION_DURATION_MAX_NS = 2940; // longest conversion
	localparam int          CONV_CYCLES  = CONV_OSC_CLOCKS * OSC_PERIOD_NS * SYS_CLK_MHZ / 1000;
	localparam int          CONV_MAX_CYC = CONVERSION_DURATION_MAX_NS * SYS_CLK_MHZ / 1000;
	localparam int          CONV_W       = 10;                 // conversion counter width
	localparam logic [9:0]  CONV_LAST    = 10'(CONV_CYCLES - 1);

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FRAME,
		ST_CONV
	} sacs_state_t;

endpackage

// ---- hdl/sacs_sync2.sv ----
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module sacs_sync2 import sacs_pkg::*; #(
	parameter int          W       = 13,
	parameter logic [12:0] RST_VAL = SYNC_RST
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// levels in and out
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// ----------------------------------------------------------------
	// state: first stage is read only by the second
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;    // first stage, may be metastable
		logic [W-1:0] stable;  // second stage, safe to use
	} sacs_sync_t;

	sacs_sync_t st_q;
	sacs_sync_t st_d;

	// shift each bit one stage on
	always_comb begin
		st_d.meta   = async_i;
		st_d.stable = st_q.meta;
	end

	// reset to idle pin levels so no false edge shows at release
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_q <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_o = st_q.stable;

endmodule

// ---- hdl/sacs_edge_counter.sv ----
// gray coded edge counter on the serial clock, cleared by the idle frame
`timescale 1ns/1ps
module sacs_edge_counter import sacs_pkg::*; (
	// link clock (or its inverse) and frame clear
	input  wire logic             edge_clk_i,
	input  wire logic             clear_i,
	// count for the system domain
	output logic      [CNT_W-1:0] gray_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] bin;   // edges seen in this frame
		logic [CNT_W-1:0] gray;  // same count, one bit changes per edge
	} sacs_cnt_t;

	sacs_cnt_t st_q;
	sacs_cnt_t st_d;

	// count up and stop at the top so the gray code never wraps
	always_comb begin
		st_d = st_q;
		if (st_q.bin != '1) begin
			st_d.bin = st_q.bin + 5'h01;
		end
		st_d.gray = st_d.bin ^ (st_d.bin >> 1);
	end

	// the clock may stop between frames, so the frame's own idle level clears
	always_ff @(posedge edge_clk_i or posedge clear_i) begin
		if (clear_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign gray_o = st_q.gray;

endmodule

// ---- hdl/sacs_cycle_sequencer.sv ----
// cycle sequencer of a 16-bit serial successive approximation converter
// Contract
// - one initialization frame needed before valid results
// - valid init gives marker word next frame
// - frame sync low with select low starts init
// - init ends on select rise or sync rise
// - sampling spans 20 clocks from fifth clock
// - conversion starts after 24th falling edge
// - conversion takes 22 oscillator clocks, bounded time
// - new frame during conversion aborts, marker follows
// - each frame shifts previous frame's result
// - sixteen bits, most significant bit first
// - output floats after 17th rise or select rise
// - later bits change on rising serial clock
// - select fall drives most significant bit
// - frame sync rise drives most significant bit
// - power down after conversion, wake on frame
// - frame sync fall starts the edge count
// - straight binary result coding passed through
`timescale 1ns/1ps
module sacs_cycle_sequencer import sacs_pkg::*; (
	// system clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	// serial link
	input  wire logic        link_sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        frame_sync_in_i,
	input  wire logic        frame_sync_used_i,
	output logic             sdo_o,
	output logic             sdo_oe_n_o,
	// successive approximation result
	input  wire logic [15:0] sar_code_i,
	// status
	output logic             sampling_o,
	output logic             conv_busy_o,
	output logic             power_down_o,
	output logic             init_done_o
);

	// ----------------------------------------------------------------
	// core state
	// ----------------------------------------------------------------
	typedef struct packed {
		sacs_state_t       state;      // sequencer state
		logic              init_done;  // an initialization frame was seen
		logic [15:0]       word;       // word shifted out in the current frame
		logic              sdo;        // serial data bit
		logic              sdo_oe_n;   // low while the data pin is driven
		logic [CONV_W-1:0] conv_cnt;   // system cycles into the conversion
		logic              cs_n_prev;  // select level one cycle ago
		logic              fs_prev;    // frame sync level one cycle ago
		logic              sampling;   // sampling window open
		logic              busy;       // converting
		logic              pwr_down;   // powered down between frames
		logic [CNT_W-1:0]  fall_prev;  // falling count one cycle ago
	} sacs_core_t;

	sacs_core_t st_q;  // registered state
	sacs_core_t st_d;  // next state

	// ----------------------------------------------------------------
	// link domain: edge counters
	// ----------------------------------------------------------------
	logic             link_clear;  // frame idle, holds both counters at zero
	logic [CNT_W-1:0] rise_gray;   // rising edges, link domain
	logic [CNT_W-1:0] fall_gray;   // falling edges, link domain

	// counting starts at select low, or at frame sync fall when it is used
	assign link_clear = cs_n_i | (frame_sync_used_i & frame_sync_in_i);

	// rising edges place the output bits
	sacs_edge_counter u_rise_cnt (
		.edge_clk_i (link_sclk_i),
		.clear_i    (link_clear),
		.gray_o     (rise_gray)
	);

	// falling edges close sampling and time conversion start
	sacs_edge_counter u_fall_cnt (
		.edge_clk_i (~link_sclk_i),
		.clear_i    (link_clear),
		.gray_o     (fall_gray)
	);

	// ----------------------------------------------------------------
	// crossing into the system domain
	// ----------------------------------------------------------------
	logic [12:0]      sync_out;   // synchronised pins and counts
	logic             cs_n_s;     // select, system domain
	logic             fs_s;       // frame sync, system domain
	logic             fs_used_s;  // frame sync strap, system domain
	logic [CNT_W-1:0] rise_bin;   // rising edge count
	logic [CNT_W-1:0] fall_bin;   // falling edge count

	// gray counts change one bit per edge, so each sample is a real count
	// limitation: the frame clear drops a count to zero in one step, so a count is
	// only trusted in cycles before the closing pin edge is seen
	sacs_sync2 #(
		.W       (13),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk_i   (sys_clk_i),
		.reset_i (reset_i),
		.async_i ({cs_n_i, frame_sync_in_i, frame_sync_used_i, rise_gray, fall_gray}),
		.sync_o  (sync_out)
	);

	// gray to binary
	function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b[CNT_W-1] = g[CNT_W-1];
		for (int i = CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	assign cs_n_s    = sync_out[12];
	assign fs_s      = sync_out[11];
	assign fs_used_s = sync_out[10];
	assign rise_bin  = gray2bin(sync_out[9:5]);
	assign fall_bin  = gray2bin(sync_out[4:0]);

	// ----------------------------------------------------------------
	// frame events
	// ----------------------------------------------------------------
	logic cs_fall;    // select went low
	logic cs_rise;    // select went high
	logic fs_rise;    // frame sync rose with select low
	logic start;      // a new frame begins
	logic frame_end;  // the current frame is over

	assign cs_fall   = st_q.cs_n_prev & ~cs_n_s;
	assign cs_rise   = ~st_q.cs_n_prev & cs_n_s;
	assign fs_rise   = fs_used_s & ~st_q.fs_prev & fs_s & ~cs_n_s;
	assign start     = cs_fall | fs_rise;
	assign frame_end = cs_rise | fs_rise;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d           = st_q;
		st_d.cs_n_prev = cs_n_s;
		st_d.fs_prev   = fs_s;
		// the counters clear in the same instant as the closing edge, so the
		// frame is classified on the count held one cycle earlier
		st_d.fall_prev = fall_bin;
		case (st_q.state)
			// powered down, waiting for a frame
			ST_IDLE: begin
				st_d.state = ST_IDLE;
			end
			// frame running: shift out and count edges
			ST_FRAME: begin
				if (fall_bin >= CONV_START_EDGE) begin
					st_d.state    = ST_CONV;
					st_d.conv_cnt = '0;
				end else if (frame_end) begin
					// a short frame is the initialization frame
					if (st_q.fall_prev >= INIT_MIN_EDGES
						&& st_q.fall_prev <= INIT_MAX_EDGES) begin
						st_d.init_done = 1'b1;
						st_d.word      = MARKER_WORD;
					end
					st_d.state = ST_IDLE;
				end
				// later bits follow the rising edges, then the pin floats
				if (rise_bin >= HIZ_RISE_EDGE) begin
					st_d.sdo_oe_n = 1'b1;
				end else if (rise_bin != '0 && rise_bin <= LAST_BIT_EDGE) begin
					st_d.sdo = st_q.word[4'(LAST_BIT_EDGE) - rise_bin[3:0]];
				end
			end
			// conversion on the modelled oscillator time base
			ST_CONV: begin
				st_d.conv_cnt = st_q.conv_cnt + 10'h001;
				if (st_q.conv_cnt == CONV_LAST) begin
					// without initialization the result is not trusted
					st_d.word     = st_q.init_done ? sar_code_i : MARKER_WORD;
					st_d.state    = ST_IDLE;
					st_d.conv_cnt = '0;
				end
			end
			default: begin
				st_d.state = ST_IDLE;
			end
		endcase
		// a select rise floats the pin even before the 17th edge
		if (cs_rise) begin
			st_d.sdo_oe_n = 1'b1;
		end
		// a new frame wakes the block and drives the first bit
		if (start) begin
			if (st_q.state == ST_CONV) begin
				st_d.word     = MARKER_WORD;
				st_d.conv_cnt = '0;
			end
			st_d.state    = ST_FRAME;
			st_d.sdo_oe_n = 1'b0;
			st_d.sdo      = st_d.word[WORD_BITS-1];
		end
		// status views of the new state
		st_d.sampling = (st_d.state == ST_FRAME) && (rise_bin >= SAMPLE_FIRST_EDGE)
			&& (fall_bin < CONV_START_EDGE);
		st_d.busy     = (st_d.state == ST_CONV);
		st_d.pwr_down = (st_d.state == ST_IDLE);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q.state     <= ST_IDLE;
			st_q.init_done <= 1'b0;
			st_q.word      <= WORD_RST;
			st_q.sdo       <= 1'b0;
			st_q.sdo_oe_n  <= 1'b1;
			st_q.conv_cnt  <= '0;
			st_q.cs_n_prev <= 1'b1;
			st_q.fs_prev   <= 1'b1;
			st_q.sampling  <= 1'b0;
			st_q.busy      <= 1'b0;
			st_q.pwr_down  <= 1'b1;
			st_q.fall_prev <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign sdo_o        = st_q.sdo;
	assign sdo_oe_n_o   = st_q.sdo_oe_n;
	assign sampling_o   = st_q.sampling;
	assign conv_busy_o  = st_q.busy;
	assign power_down_o = st_q.pwr_down;
	assign init_done_o  = st_q.init_done;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	localparam int CONV_MAX_LEN = CONV_MAX_CYC;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	// frame reaches the launch edge
	sequence s_conv_begin;
		st_q.state == ST_FRAME && fall_bin >= CONV_START_EDGE && !start;
	endsequence

	// short frame closes
	sequence s_init_end;
		st_q.state == ST_FRAME && frame_end && !start && fall_bin < CONV_START_EDGE
			&& st_q.fall_prev >= INIT_MIN_EDGES && st_q.fall_prev <= INIT_MAX_EDGES;
	endsequence

	// frame closes with a count that is neither init nor launch
	sequence s_other_end;
		st_q.state == ST_FRAME && frame_end && !start && fall_bin < CONV_START_EDGE
			&& (st_q.fall_prev < INIT_MIN_EDGES || st_q.fall_prev > INIT_MAX_EDGES);
	endsequence

	// last conversion cycle, left alone
	sequence s_conv_last;
		st_q.state == ST_CONV && st_q.conv_cnt == CONV_LAST && !start;
	endsequence

	a_abort_marker: assert property (
		(st_q.state == ST_CONV && start) |=> (st_q.word == MARKER_WORD && st_q.sdo
			&& !st_q.sdo_oe_n && st_q.state == ST_FRAME))
		else $error("aborted conversion did not give the marker");

	a_init_marker: assert property (
		s_init_end |=> (st_q.init_done && st_q.word == MARKER_WORD && st_q.pwr_down))
		else $error("initialization frame did not load the marker");

	a_conv_launch: assert property (
		s_conv_begin |=> (st_q.busy && st_q.conv_cnt == '0)
			##1 (st_q.conv_cnt == 10'h001 || $past(start)))
		else $error("conversion did not start after the launch edge");

	a_conv_bound: assert property (
		st_q.busy |-> (int'(st_q.conv_cnt) < CONV_MAX_LEN))
		else $error("conversion ran past its longest time");

	a_conv_finish: assert property (
		s_conv_last |=> (st_q.pwr_down && !st_q.busy))
		else $error("conversion did not end in power down");

	a_result_load: assert property (
		(s_conv_last ##0 st_q.init_done) |=> (st_q.word == $past(sar_code_i)))
		else $error("finished conversion did not load the result");

	a_uninit_marker: assert property (
		(s_conv_last ##0 !st_q.init_done) |=> (st_q.word == MARKER_WORD))
		else $error("result loaded before initialization");

	a_float_17: assert property (
		(st_q.state == ST_FRAME && rise_bin >= HIZ_RISE_EDGE && !start) |=> st_q.sdo_oe_n)
		else $error("output still driven after the 17th rising edge");

	a_float_cs: assert property (
		(cs_rise && !start) |=> st_q.sdo_oe_n)
		else $error("output still driven after select rose");

	a_msb_first: assert property (
		(start && st_q.state != ST_CONV && !frame_end) |=> (!st_q.sdo_oe_n
			&& st_q.sdo == st_q.word[WORD_BITS-1]))
		else $error("first bit is not the most significant bit");

	a_bit_order: assert property (
		(st_q.state == ST_FRAME && !st_q.sdo_oe_n && rise_bin != '0 && rise_bin <= LAST_BIT_EDGE
			&& fall_bin < CONV_START_EDGE && !frame_end && !start)
			|=> (st_q.sdo == st_q.word[4'(LAST_BIT_EDGE) - $past(rise_bin[3:0])]))
		else $error("output bit out of order");

	a_sample_open: assert property (
		(st_q.state == ST_FRAME && rise_bin >= SAMPLE_FIRST_EDGE && fall_bin < CONV_START_EDGE
			&& !start && !frame_end) |=> st_q.sampling)
		else $error("sampling window not open");

	a_other_keep: assert property (
		s_other_end |=> (st_q.word == $past(st_q.word) && st_q.pwr_down
			&& st_q.init_done == $past(st_q.init_done)))
		else $error("cut frame changed the stored word");

	a_wake_frame: assert property (
		start |=> (!st_q.pwr_down && st_q.state == ST_FRAME && !st_q.busy))
		else $error("new frame did not wake the sequencer");

	a_sync_msb: assert property (
		(fs_rise && st_q.state != ST_CONV) |=> (!st_q.sdo_oe_n
			&& st_q.sdo == st_q.word[WORD_BITS-1]))
		else $error("frame sync rise did not drive the most significant bit");

endmodule

// ---- testbench/sacs_host_model.sv ----
// host side model: drives select, frame sync and serial clock, reads data
`timescale 1ns/1ps
module sacs_host_model (
	// link pins driven by the host
	output logic      link_sclk_o,
	output logic      cs_n_o,
	output logic      fs_o,
	// resolved serial data line
	input  wire logic sdo_i
);
	int k; // falling edges given so far in this frame

	// -----------------------------------------------------------
	// idle levels
	// -----------------------------------------------------------
	initial begin
		link_sclk_o = 1'b0; // clock idles low and stands still between frames
		cs_n_o = 1'b1;
		fs_o = 1'b0;
		k = 0;
	end

	// -----------------------------------------------------------
	// one frame: fsm picks frame sync start, slow stretches low phase
	// -----------------------------------------------------------
	task automatic frame(input bit fsm, input int falls, input bit slow,
			output logic [15:0] w);
		w = 16'h0000;
		k = 0;
		#1.7; // link edges sit off the system clock grid
		cs_n_o = 1'b0; // select falls, or is held low for frame sync use
		if (fsm) begin
			#15;
			fs_o = 1'b1; // half a clock of setup after select
		end
		#40;
		fs_o = 1'b0; // frame sync high well over half a clock
		#15;
		for (int i = 1; i <= falls; i++) begin
			// output is resynchronised inside, so bits are taken late in the low phase
			if (i <= 16)
				w[16-i] = sdo_i;
			link_sclk_o = 1'b1;
			#15;
			k = i;
			link_sclk_o = 1'b0;
			#15;
			if (slow)
				#45;
		end
		// init frames stop at 1..8 falls, normal ones hold past the 16th
		if (!fsm)
			cs_n_o = 1'b1;
		#20;
	endtask
endmodule

// ---- testbench/serial_adc_cycle_sequencer_test.sv ----
// self-checking bench of the serial converter cycle sequencer
`timescale 1ns/1ps
module serial_adc_cycle_sequencer_test import sacs_pkg::*;;
	// -----------------------------------------------------------
	// pins, counters and monitors
	// -----------------------------------------------------------
	logic        sys_clk, reset, strap, sdo, sdo_oe_n;
	logic        sdo_last = 1'b0;
	logic        sclk, cs_n, fs, sampling, busy, pdn, init_done;
	logic [15:0] sar_code, w;
	wire         sdo_line;
	int          failures, tests_run;
	int          busy_n = 0, busy_len = 0, samp_n = 0, samp_len = 0;

	// ordinary frames: mode, clocks, slow, code converted, word expected
	typedef struct {bit fsm; int falls; bit slow; logic [15:0] code; logic [15:0] exp;} sacs_row_t;
	sacs_row_t rows [6] = '{
		'{0, 8, 0, 16'h0000, WORD_RST},
		'{0, 24, 0, 16'hA5C3, MARKER_WORD},
		'{0, 24, 0, 16'h0000, 16'hA5C3},
		'{0, 24, 1, 16'hFFFF, 16'h0000},
		'{0, 24, 0, 16'h8001, 16'hFFFF},
		'{0, 24, 0, 16'h2B6E, 16'h8001}
	};

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// a released line shows the inverse of its last level, having no pull
	assign sdo_line = sdo_oe_n ? ~sdo_last : sdo;

	// lengths of the busy and sampling levels, in system cycles
	always @(posedge sys_clk) begin
		if (!sdo_oe_n)
			sdo_last <= sdo;
		busy_n <= busy ? busy_n + 1 : 0;
		samp_n <= sampling ? samp_n + 1 : 0;
		if (!busy && busy_n != 0)
			busy_len <= busy_n;
		if (!sampling && samp_n != 0)
			samp_len <= samp_n;
	end

	always @(negedge sclk) begin
		if (sacs_host_model_i.k == 16)
			chk("drive at fall 16", 16'h0, 16'(sdo_oe_n));
		if (sacs_host_model_i.k == 19)
			chk("float after rise 17", 16'h1, 16'(sdo_oe_n));
	end

	sacs_cycle_sequencer sacs_cycle_sequencer_i (
		.sys_clk_i(sys_clk), .reset_i(reset), .link_sclk_i(sclk),
		.cs_n_i(cs_n), .frame_sync_in_i(fs), .frame_sync_used_i(strap),
		.sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .sar_code_i(sar_code),
		.sampling_o(sampling), .conv_busy_o(busy), .power_down_o(pdn),
		.init_done_o(init_done)
	);

	sacs_host_model sacs_host_model_i (
		.link_sclk_o(sclk), .cs_n_o(cs_n), .fs_o(fs), .sdo_i(sdo_line)
	);

	// -----------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (exp !== got) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic idle_check();
		chk("idle enable", 16'h1, 16'(sdo_oe_n));
		chk("idle power down", 16'h1, 16'(pdn));
		chk("idle flags", 16'h0, {13'h0, sampling, busy, init_done});
		$display("idle check done");
	endtask

	// wait out a conversion; window spans rise 5 to fall 24 of the frame
	task automatic conv_wait(input bit slow);
		int n, e;
		n = 0;
		e = (19 * (slow ? 75 : 30) + 15) / 5;
		chk("busy after fall 24", 16'h1, 16'(busy));
		while (busy === 1'b1 && n < 700) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (2) @(negedge sys_clk);
		chk("conv length", 16'h1, 16'(busy_len >= CONV_CYCLES - 1 && busy_len <= CONV_CYCLES + 1));
		chk("sample length", 16'h1, 16'(samp_len >= e - 2 && samp_len <= e + 2));
		chk("power down", 16'h1, 16'(pdn));
	endtask

	// one frame with its word compared over the bits actually clocked
	task automatic run(input bit fsm, input int falls, input bit slow,
			input logic [15:0] code, input logic [15:0] exp);
		int sh;
		sh = falls >= 16 ? 0 : 16 - falls;
		@(negedge sys_clk);
		sar_code = code;
		sacs_host_model_i.frame(fsm, falls, slow, w);
		repeat (3) @(negedge sys_clk);
		chk("shifted word", exp >> sh, w >> sh);
		if (falls >= 24)
			conv_wait(slow);
		$display("frame of %0d clocks done", falls);
	endtask

	// -----------------------------------------------------------
	// watchdog and main sequence
	// -----------------------------------------------------------
	initial begin
		#200000;
		failures++;
		$display("ERROR watchdog expected end seen timeout");
		give_verdict();
	end

	initial begin
		reset = 1'b1;
		strap = 1'b0;
		sar_code = 16'h0000;
		failures = 0;
		tests_run = 0;
		repeat (12) @(negedge sys_clk);
		idle_check();
		reset = 1'b0;
		repeat (4) @(negedge sys_clk);
		idle_check();
		foreach (rows[i]) begin
			run(rows[i].fsm, rows[i].falls, rows[i].slow, rows[i].code, rows[i].exp);
			chk("init done", 16'h1, 16'(init_done));
		end
		// a short frame while converting aborts it and shifts out the marker word
		@(negedge sys_clk);
		sar_code = 16'h1357;
		sacs_host_model_i.frame(0, 24, 0, w);
		chk("word before abort", 16'h2B6E, w);
		sacs_host_model_i.frame(0, 9, 0, w);
		chk("word after abort", MARKER_WORD >> 7, w >> 7);
		repeat (3) @(negedge sys_clk);
		chk("busy after abort", 16'h0, 16'(busy));
		chk("float on select rise", 16'h1, 16'(sdo_oe_n));
		run(0, 24, 0, 16'h4C4C, MARKER_WORD);
		$display("abort test done");
		// frame sync variant from a fresh reset
		reset = 1'b1;
		strap = 1'b1;
		repeat (12) @(negedge sys_clk);
		reset = 1'b0;
		repeat (4) @(negedge sys_clk);
		idle_check();
		run(1, 4, 0, 16'h0000, WORD_RST);
		run(1, 24, 0, 16'h0F0F, MARKER_WORD);
		chk("init done by sync", 16'h1, 16'(init_done));
		run(1, 24, 1, 16'h6D6D, 16'h0F0F);
		$display("frame sync test done");
		give_verdict();
	end
endmodule
